// file: inc/ipv_params.svh
// Constants of the interrupt priority vector controller: offsets, fields, resets.
// Assumes a 32-bit register port addressed by byte, one word per register.
// Function
// - Seven levels, seven highest, one lowest
// - Fixed internal sources request at level six/four
// - Four internal sources have programmable level one-six
// - External sources map to levels seven,six,five,three,two,one; the four GP pins to level four
// - Only highest pending enabled level goes to core
// - Acknowledge cycle answered with vector on data
// - Vector is five base bits plus level
// - Mask bit one disables that source
// - Pending register shows masked requests too
// - Never autovector; always supply a vector, the programmed one once base is written
// - Unprogrammed base answers vector 0x0f
// - Lines one, two, three, six have polarity and edge/level select; pen has polarity only; emulator and GP pins have neither
// - Edge requests cleared by writing one; others at source
`ifndef IPV_PARAMS_SVH
`define IPV_PARAMS_SVH

`define IPV_ADDR_W 8
`define IPV_NSRC 22

`define IPV_OFF_BASE 8'h00
`define IPV_OFF_CTRL 8'h04
`define IPV_OFF_MASK 8'h08
`define IPV_OFF_STATUS 8'h0c
`define IPV_OFF_PEND 8'h10
`define IPV_OFF_LVLCFG 8'h14

`define IPV_RST_BASE 5'h00
`define IPV_RST_CTRL 16'h0000
`define IPV_RST_MASK 22'h3fffff
`define IPV_RST_LVLCFG 12'h924
`define IPV_UNINIT_VEC 8'h0f

`define IPV_LINE_ONE_POLARITY 15
`define IPV_POL2 14
`define IPV_POL3 13
`define IPV_POL6 12
`define IPV_ET1 11
`define IPV_ET2 10
`define IPV_ET3 9
`define IPV_ET6 8
`define IPV_POL5 7

`define IPV_SRC_LINE1 0
`define IPV_SRC_LINE2 1
`define IPV_SRC_LINE3 2
`define IPV_SRC_PEN 3
`define IPV_SRC_LINE6 4
`define IPV_SRC_EMU 5
`define IPV_SRC_TIMER1 6
`define IPV_SRC_PWM1 7
`define IPV_SRC_TIMER2 8
`define IPV_SRC_PWM2 9
`define IPV_SRC_SPI1 10
`define IPV_SRC_UART2 11
`define IPV_SRC_GP0 18

`endif

// file: inc/ipv_pkg.sv
// Types shared by the interrupt priority vector controller.
// Assumes the constants header is compiled alongside.
package ipv_pkg;
  typedef logic [2:0] ipv_level_t;
  typedef enum logic [1:0] {
    IPV_IDLE = 2'b01,
    IPV_ANSWER = 2'b10
  } ipv_ack_state_t;
endpackage

// file: hdl/ipv_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to sys_clk; only stage two is read outside.
`timescale 1ns/1ps
module ipv_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins in, synchronised out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;
endmodule

// file: hdl/ipv_prio.sv
// Combinational priority resolver: maps each enabled source to its level
// and returns the highest level present, zero when nothing is enabled.
// Assumes enables already have the mask applied.
`timescale 1ns/1ps
`include "ipv_params.svh"
module ipv_prio (
  // Enabled requests
  input wire logic [`IPV_NSRC-1:0] enabled,
  // Programmable levels for the four configurable sources
  input wire logic [11:0] level_cfg,
  // Highest level
  output ipv_pkg::ipv_level_t top_level
);
  // Zero disables a configurable source; seven is pulled down to six
  function automatic ipv_pkg::ipv_level_t cfg_level(input logic [2:0] f);
    cfg_level = (f == 3'h7) ? 3'h6 : f;
  endfunction

  function automatic ipv_pkg::ipv_level_t src_level(input int idx, input logic [11:0] cfg);
    unique case (idx)
      `IPV_SRC_LINE1: src_level = 3'h1;
      `IPV_SRC_LINE2: src_level = 3'h2;
      `IPV_SRC_LINE3: src_level = 3'h3;
      `IPV_SRC_PEN: src_level = 3'h5;
      `IPV_SRC_LINE6: src_level = 3'h6;
      `IPV_SRC_EMU: src_level = 3'h7;
      `IPV_SRC_TIMER1, `IPV_SRC_PWM1: src_level = 3'h6;
      `IPV_SRC_TIMER2: src_level = cfg_level(cfg[2:0]);
      `IPV_SRC_PWM2: src_level = cfg_level(cfg[5:3]);
      `IPV_SRC_SPI1: src_level = cfg_level(cfg[8:6]);
      `IPV_SRC_UART2: src_level = cfg_level(cfg[11:9]);
      default: src_level = 3'h4;
    endcase
  endfunction

  logic [7:0] hits;

  always_comb begin
    hits = 8'h00;
    for (int i = 0; i < `IPV_NSRC; i++) begin
      if (enabled[i]) begin
        hits[src_level(i, level_cfg)] = 1'b1;
      end
    end
    top_level = 3'h0;
    // Ascending scan so the last hit, the highest level, wins
    for (int l = 1; l < 8; l++) begin
      if (hits[l]) begin
        top_level = 3'(l);
      end
    end
  end
endmodule

// file: hdl/ipv_ctrl.sv
// Top of the interrupt priority vector controller: request collection,
// register port, level output to the core and acknowledge vector answer.
// Assumes peripheral requests are levels on sys_clk; pins are asynchronous.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "ipv_params.svh"
module ipv_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [`IPV_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // External request pins
  input wire logic external_request_line_one,
  input wire logic external_request_line_two,
  input wire logic external_request_line_three,
  input wire logic external_request_line_six,
  input wire logic pen_request_pin,
  input wire logic emulator_request_input,
  input wire logic [3:0] gp_request_n,
  // Internal peripheral requests
  input wire logic timer1_req,
  input wire logic pwm1_req,
  input wire logic timer2_req,
  input wire logic pwm2_req,
  input wire logic spi1_req,
  input wire logic uart2_req,
  input wire logic spi2_req,
  input wire logic uart1_req,
  input wire logic watchdog_req,
  input wire logic rtc_req,
  input wire logic rti_req,
  input wire logic keyboard_req,
  // Core side
  output ipv_pkg::ipv_level_t irq_level,
  input wire logic interrupt_acknowledge_cycle,
  input wire logic [2:0] interrupt_acknowledge_cycle_level,
  output logic [7:0] vector_data,
  output logic vector_valid
);
  // Synchronised pins
  logic [9:0] pins_raw;
  logic [9:0] pins;

  assign pins_raw = {gp_request_n, emulator_request_input, external_request_line_six,
                     pen_request_pin, external_request_line_three,
                     external_request_line_two, external_request_line_one};

  ipv_sync #(.W(10)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(pins_raw),
    .pin_sync(pins)
  );

  // Register state
  logic [4:0] vector_base_register_reg;
  logic [4:0] vector_base_register_next;
  logic base_set_reg;
  logic base_set_next;
  logic [15:0] external_request_control_register_reg;
  logic [15:0] external_request_control_register_next;
  logic [`IPV_NSRC-1:0] mask_reg;
  logic [`IPV_NSRC-1:0] mask_next;
  logic [11:0] level_cfg_reg;
  logic [11:0] level_cfg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Edge detection state for lines one, two, three, six
  logic [3:0] asserted_prev_reg;
  logic [3:0] asserted_prev_next;
  logic [3:0] edge_latch_reg;
  logic [3:0] edge_latch_next;

  // Priority and acknowledge state
  ipv_pkg::ipv_level_t level_reg;
  ipv_pkg::ipv_level_t level_next;
  ipv_pkg::ipv_ack_state_t ack_state_reg;
  ipv_pkg::ipv_ack_state_t ack_state_next;
  logic [7:0] vector_reg;
  logic [7:0] vector_next;

  // Request vectors
  logic [3:0] pol;
  logic [3:0] edge_mode;
  logic [3:0] line_pin;
  logic [3:0] asserted;
  logic [3:0] rise;
  logic [3:0] w1c;
  logic pen_asserted;
  logic [`IPV_NSRC-1:0] request_pending_register;
  logic [`IPV_NSRC-1:0] request_status_register;
  ipv_pkg::ipv_level_t top_level;

  logic wr_base;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_status;
  logic wr_lvl;

  // One decoder for every write strobe, so no offset can be mistyped twice
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  // Polarity zero asserts low, one asserts high
  function automatic logic pin_active(input logic pin, input logic pol_bit);
    pin_active = ~(pin ^ pol_bit);
  endfunction

  assign wr_base = reg_wr && addr_is(reg_addr, `IPV_OFF_BASE);
  assign wr_ctrl = reg_wr && addr_is(reg_addr, `IPV_OFF_CTRL);
  assign wr_mask = reg_wr && addr_is(reg_addr, `IPV_OFF_MASK);
  assign wr_status = reg_wr && addr_is(reg_addr, `IPV_OFF_STATUS);
  assign wr_lvl = reg_wr && addr_is(reg_addr, `IPV_OFF_LVLCFG);

  // Order within these nibbles: line one, two, three, six
  assign pol = {external_request_control_register_reg[`IPV_POL6],
                external_request_control_register_reg[`IPV_POL3],
                external_request_control_register_reg[`IPV_POL2],
                external_request_control_register_reg[`IPV_LINE_ONE_POLARITY]};
  assign edge_mode = {external_request_control_register_reg[`IPV_ET6],
                      external_request_control_register_reg[`IPV_ET3],
                      external_request_control_register_reg[`IPV_ET2],
                      external_request_control_register_reg[`IPV_ET1]};
  assign line_pin = {pins[4], pins[2], pins[1], pins[0]};

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      asserted[i] = pin_active(line_pin[i], pol[i]);
    end
    pen_asserted = pin_active(pins[3], external_request_control_register_reg[`IPV_POL5]);
  end
  assign rise = asserted & ~asserted_prev_reg & edge_mode;
  assign w1c = wr_status ? {reg_wdata[`IPV_SRC_LINE6], reg_wdata[`IPV_SRC_LINE3],
                            reg_wdata[`IPV_SRC_LINE2], reg_wdata[`IPV_SRC_LINE1]} : 4'h0;

  always_comb begin
    asserted_prev_next = asserted;
    // A new edge in the clearing cycle keeps the latch set
    edge_latch_next = (rise | (edge_latch_reg & ~w1c)) & edge_mode;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      asserted_prev_reg <= 4'h0;
      edge_latch_reg <= 4'h0;
    end else begin
      asserted_prev_reg <= asserted_prev_next;
      edge_latch_reg <= edge_latch_next;
    end
  end

  // Level requests follow their source; edge requests come from the latch
  always_comb begin
    request_pending_register = '0;
    request_pending_register[`IPV_SRC_LINE1] = edge_mode[0] ? edge_latch_reg[0] : asserted[0];
    request_pending_register[`IPV_SRC_LINE2] = edge_mode[1] ? edge_latch_reg[1] : asserted[1];
    request_pending_register[`IPV_SRC_LINE3] = edge_mode[2] ? edge_latch_reg[2] : asserted[2];
    request_pending_register[`IPV_SRC_PEN] = pen_asserted;
    request_pending_register[`IPV_SRC_LINE6] = edge_mode[3] ? edge_latch_reg[3] : asserted[3];
    request_pending_register[`IPV_SRC_EMU] = pins[5];
    request_pending_register[`IPV_SRC_TIMER1] = timer1_req;
    request_pending_register[`IPV_SRC_PWM1] = pwm1_req;
    request_pending_register[`IPV_SRC_TIMER2] = timer2_req;
    request_pending_register[`IPV_SRC_PWM2] = pwm2_req;
    request_pending_register[`IPV_SRC_SPI1] = spi1_req;
    request_pending_register[`IPV_SRC_UART2] = uart2_req;
    request_pending_register[17:12] = {keyboard_req, rti_req, rtc_req, watchdog_req,
                                       uart1_req, spi2_req};
    request_pending_register[21:`IPV_SRC_GP0] = ~pins[9:6];
  end

  assign request_status_register = request_pending_register & ~mask_reg;

  ipv_prio u_prio (
    .enabled(request_status_register),
    .level_cfg(level_cfg_reg),
    .top_level(top_level)
  );

  // Level to the core is refreshed every cycle, so a lower request that
  // waited behind a serviced one shows as soon as it is the highest
  always_comb begin
    level_next = top_level;
  end

  // Acknowledge answer: vector one cycle after the cycle is seen
  always_comb begin
    ack_state_next = ack_state_reg;
    vector_next = vector_reg;
    unique case (ack_state_reg)
      ipv_pkg::IPV_IDLE: begin
        if (interrupt_acknowledge_cycle) begin
          ack_state_next = ipv_pkg::IPV_ANSWER;
          // Level comes from the core's address lines, not from our own output
          vector_next = base_set_reg ? {vector_base_register_reg, interrupt_acknowledge_cycle_level}
                                     : `IPV_UNINIT_VEC;
        end
      end
      ipv_pkg::IPV_ANSWER: begin
        ack_state_next = interrupt_acknowledge_cycle ? ipv_pkg::IPV_ANSWER : ipv_pkg::IPV_IDLE;
      end
      default: begin
        ack_state_next = ipv_pkg::IPV_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_reg <= 3'h0;
      ack_state_reg <= ipv_pkg::IPV_IDLE;
      vector_reg <= 8'h00;
    end else begin
      level_reg <= level_next;
      ack_state_reg <= ack_state_next;
      vector_reg <= vector_next;
    end
  end

  // Register writes
  always_comb begin
    vector_base_register_next = vector_base_register_reg;
    base_set_next = base_set_reg;
    external_request_control_register_next = external_request_control_register_reg;
    mask_next = mask_reg;
    level_cfg_next = level_cfg_reg;
    if (wr_base) begin
      vector_base_register_next = reg_wdata[7:3];
      base_set_next = 1'b1;
    end
    if (wr_ctrl) begin
      external_request_control_register_next = reg_wdata[15:0] & 16'hff80;
    end
    if (wr_mask) begin
      mask_next = reg_wdata[`IPV_NSRC-1:0];
    end
    if (wr_lvl) begin
      level_cfg_next = reg_wdata[11:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `IPV_OFF_BASE: rdata_next = {24'h000000, vector_base_register_reg, 3'h0};
        `IPV_OFF_CTRL: rdata_next = {16'h0000, external_request_control_register_reg};
        `IPV_OFF_MASK: rdata_next = {10'h000, mask_reg};
        `IPV_OFF_STATUS: rdata_next = {10'h000, request_status_register};
        `IPV_OFF_PEND: rdata_next = {10'h000, request_pending_register};
        `IPV_OFF_LVLCFG: rdata_next = {20'h00000, level_cfg_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vector_base_register_reg <= `IPV_RST_BASE;
      base_set_reg <= 1'b0;
      external_request_control_register_reg <= `IPV_RST_CTRL;
      mask_reg <= `IPV_RST_MASK;
      level_cfg_reg <= `IPV_RST_LVLCFG;
      rdata_reg <= 32'h0000_0000;
    end else begin
      vector_base_register_reg <= vector_base_register_next;
      base_set_reg <= base_set_next;
      external_request_control_register_reg <= external_request_control_register_next;
      mask_reg <= mask_next;
      level_cfg_reg <= level_cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // Autovector is never signalled; the core always gets a vector
  assign irq_level = level_reg;
  assign vector_data = vector_reg;
  assign vector_valid = (ack_state_reg == ipv_pkg::IPV_ANSWER);
  assign reg_rdata = rdata_reg;
endmodule

// file: bench/ipv_ctrl_props.sv
// Checker of the controller's register and core ports.
// Assumes the bind at the foot attaches it to every controller.
`timescale 1ns/1ps
module ipv_ctrl_props (
  // Clock, reset, register port
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Requests
  input wire logic pwm1_req,
  input wire logic uart1_req,
  // Core side
  input ipv_pkg::ipv_level_t irq_level,
  input wire logic interrupt_acknowledge_cycle,
  input wire logic [2:0] interrupt_acknowledge_cycle_level,
  input wire logic [7:0] vector_data,
  input wire logic vector_valid
);
  logic [4:0] base_reg;
  logic seen_reg;
  logic [21:0] mask_reg;
  // Shadow of base and mask; bench never writes them during an acknowledge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      base_reg <= 5'h00;
      seen_reg <= 1'b0;
      mask_reg <= 22'h3fffff;
    end else if (reg_wr && reg_addr == 8'h00) begin
      base_reg <= reg_wdata[7:3];
      seen_reg <= 1'b1;
    end else if (reg_wr && reg_addr == 8'h08) begin
      mask_reg <= reg_wdata[21:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence taken_s;
    interrupt_acknowledge_cycle && !vector_valid;
  endsequence
  sequence held_s;
    vector_valid && interrupt_acknowledge_cycle;
  endsequence
  ack_answer_a: assert property (taken_s |=> vector_valid)
    else $error("acknowledge not answered");
  vec_hold_a: assert property (held_s |=> vector_valid && $stable(vector_data))
    else $error("vector not held");
  vec_drop_a: assert property (vector_valid && !interrupt_acknowledge_cycle |=> !vector_valid)
    else $error("vector outlived acknowledge");
  vec_value_a: assert property ($rose(vector_valid) |->
    vector_data == (seen_reg ? {base_reg, $past(interrupt_acknowledge_cycle_level)} : 8'h0f))
    else $error("wrong vector");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read");
  rd_unmapped_a: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  mask_all_a: assert property (mask_reg == 22'h3fffff |=> irq_level == 3'h0)
    else $error("masked request reached core");
  lvl_six_a: assert property (pwm1_req && !mask_reg[7] |=> irq_level >= 3'h6)
    else $error("level six request lost");
  lvl_four_a: assert property (uart1_req && !mask_reg[13] |=> irq_level >= 3'h4)
    else $error("level four request lost");
endmodule

bind ipv_ctrl ipv_ctrl_props ipv_ctrl_props_inst (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pwm1_req(pwm1_req), .uart1_req(uart1_req),
  .irq_level(irq_level), .interrupt_acknowledge_cycle(interrupt_acknowledge_cycle),
  .interrupt_acknowledge_cycle_level(interrupt_acknowledge_cycle_level), .vector_data(vector_data), .vector_valid(vector_valid));

// file: bench/ipv_host_model.sv
// Host core model: takes levels above its own mask, runs acknowledge cycles.
// Assumes the controller answers while acknowledge is held.
`timescale 1ns/1ps
module ipv_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Controller side
  input wire logic [2:0] irq_level,
  input wire logic [7:0] vector_data,
  input wire logic vector_valid,
  output logic ack,
  output logic [2:0] ack_level,
  // Bench side
  input wire logic [3:0] busy_cycles,
  input wire logic mask_wr,
  input wire logic [2:0] mask_val,
  output logic done,
  output logic [7:0] vec_got
);
  logic [2:0] mask_reg;
  logic [3:0] cnt_reg;
  logic [9:0] table_addr;
  // Never drives a vector itself
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_reg <= 3'h7;
      cnt_reg <= 4'h0;
      table_addr <= 10'h000;
      ack <= 1'b0;
      ack_level <= 3'h0;
      done <= 1'b0;
      vec_got <= 8'h00;
    end else begin
      done <= 1'b0;
      if (mask_wr) mask_reg <= mask_val;
      if (ack && vector_valid) begin
        ack <= 1'b0;
        ack_level <= ~ack_level; // Released lines must not keep the old level
        vec_got <= vector_data;
        table_addr <= {vector_data, 2'b00};
        mask_reg <= ack_level;
        done <= 1'b1;
      end else if (ack) begin
        // An answer that never comes is treated as a bus error
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == 4'hf) begin
          ack <= 1'b0;
          table_addr <= 10'h060;
          cnt_reg <= 4'h0;
        end
      end else if (!done && irq_level > mask_reg) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg >= busy_cycles) begin // Current instruction ends first
          ack <= 1'b1;
          ack_level <= irq_level;
          cnt_reg <= 4'h0;
        end
      end
    end
  end
endmodule

// file: bench/test_ipv_ctrl.sv
// Self-checking bench of the interrupt priority vector controller.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
module test_ipv_ctrl;
  logic sys_clk, rst, reg_wr, reg_rd, mwr, done, ack, vv, rd_d;
  logic [7:0] reg_addr, vd, vgot, b;
  logic [31:0] reg_wdata, reg_rdata;
  logic [21:0] src;
  logic [2:0] lvl, al, mval;
  logic [3:0] busy;
  logic [31:0] rq[$];
  logic [31:0] vq[$];
  logic [2:0] lv[22] = '{1, 2, 3, 5, 6, 7, 6, 6, 0, 0, 0, 0, 4, 4, 4, 4, 4, 4, 4, 4, 4, 4};
  int ord[3] = '{7, 13, 0};
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  ipv_ctrl ipv_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_request_line_one(~src[0]), .external_request_line_two(~src[1]),
    .external_request_line_three(~src[2]), .pen_request_pin(~src[3]),
    .external_request_line_six(~src[4]), .emulator_request_input(src[5]),
    .timer1_req(src[6]), .pwm1_req(src[7]), .timer2_req(src[8]), .pwm2_req(src[9]),
    .spi1_req(src[10]), .uart2_req(src[11]), .spi2_req(src[12]), .uart1_req(src[13]),
    .watchdog_req(src[14]), .rtc_req(src[15]), .rti_req(src[16]),
    .keyboard_req(src[17]), .gp_request_n(~src[21:18]), .irq_level(lvl),
    .interrupt_acknowledge_cycle(ack), .interrupt_acknowledge_cycle_level(al), .vector_data(vd),
    .vector_valid(vv));
  ipv_host_model ipv_host_model_inst (.sys_clk(sys_clk), .rst(rst), .irq_level(lvl),
    .vector_data(vd), .vector_valid(vv), .ack(ack), .ack_level(al),
    .busy_cycles(busy), .mask_wr(mwr), .mask_val(mval), .done(done), .vec_got(vgot));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Results are compared in the cycle they appear, oldest note first
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    cyc++;
    if (rd_d) check(reg_rdata, rq.pop_front());
    if (done) check({24'h0, vgot}, vq.pop_front());
    if (cyc == 6000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic core_mask(input logic [2:0] m);
    @(posedge sys_clk);
    mwr <= 1'b1;
    mval <= m;
    @(posedge sys_clk);
    mwr <= 1'b0;
  endtask
  // Source is dropped after its vector or after 80 cycles, then the core mask reopens
  task automatic finish(input int k);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!done && n < 80);
    src[k] <= 1'b0;
    repeat (5) @(posedge sys_clk);
    core_mask(3'h0);
  endtask
  task automatic serve(input int k, input logic [7:0] v);
    vq.push_back({24'h0, v});
    busy <= 4'($urandom % 8);
    src[k] <= 1'b1;
    finish(k);
  endtask
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, mwr, reg_addr, reg_wdata, mval, busy, src, b} = '0;
    void'($urandom(55));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    check({29'h0, lvl}, 32'h0);
    rd(8'h08, 32'h3fffff);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h924);
    rd(8'h20, 32'h0);
    src[6] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check({29'h0, lvl}, 32'h0);
    rd(8'h10, 32'h40);
    rd(8'h0c, 32'h0);
    src[6] <= 1'b0;
    wr(8'h08, 32'h0);
    core_mask(3'h0);
    serve(6, 8'h0f);
    b = 8'h40 + 8'(($urandom % 24) * 8); // User range, clear of reserved numbers
    wr(8'h00, {24'h0, b});
    for (int j = 8; j < 12; j++) lv[j] = 3'(1 + $urandom % 6);
    wr(8'h14, {20'h0, lv[11], lv[10], lv[9], lv[8]});
    for (int k = 0; k < 22; k++) serve(k, {b[7:3], lv[k]});
    for (int i = 0; i < 3; i++) vq.push_back({24'h0, b[7:3], lv[ord[i]]});
    src <= 22'h002081;
    for (int i = 0; i < 3; i++) finish(ord[i]);
    check({22'h0, ipv_host_model_inst.table_addr}, {22'h0, b[7:3], 3'h1, 2'b00});
    core_mask(3'h7);
    wr(8'h04, 32'h0800);
    src[0] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    src[0] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check({29'h0, lvl}, 32'h1);
    rd(8'h0c, 32'h1);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h0);
    wr(8'h04, 32'h8000);
    repeat (4) @(posedge sys_clk);
    rd(8'h0c, 32'h1);
    wr(8'h04, 32'h0);
    repeat (4) @(posedge sys_clk);
    give_verdict();
  end
endmodule
